// ==== src/bwd_pkg.sv ====
// Package for the board watchdog: port address, data codes, timing counts.
// Assumes a 50 MHz system clock and an 8-bit I/O data path.
`default_nettype none

package bwd_pkg;

    // I/O port address of the watchdog control port
    localparam logic [15:0] BWD_PORT_ADDR     = 16'h0443;
    // Data codes written to the port
    localparam logic [7:0]  BWD_CODE_REFRESH  = 8'h01;
    localparam logic [7:0]  BWD_CODE_DISARM   = 8'h00;
    // Read value layout: bit 0 shows the armed state
    localparam int          BWD_STAT_ARMED_BIT = 0;
    localparam logic [7:0]  BWD_RST_ARMED     = 8'h00;

    // Timing
    localparam longint      BWD_CLK_HZ        = 64'd50_000_000;
    localparam longint      BWD_TIMEOUT_MS    = 64'd1600;
    localparam longint      BWD_TIMEOUT_CYC   = (BWD_TIMEOUT_MS * BWD_CLK_HZ) / 64'd1000;
    // Time base tick every 1 ms
    localparam longint      BWD_TICK_US       = 64'd1000;
    localparam int          BWD_TICK_CYC      = int'((BWD_TICK_US * BWD_CLK_HZ) / 64'd1_000_000);
    // CPU reset pulse length
    localparam int          BWD_RST_PULSE_CYC = 16;

    // Expiry action choice
    typedef enum logic {
        BWD_ACT_RESET,
        BWD_ACT_IRQ
    } bwd_action_t;

    // Host I/O access grouped
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } bwd_io_req_t;

endpackage : bwd_pkg

`default_nettype wire

// ==== src/bwd_tick_div.sv ====
// Divider that makes a one-cycle enable pulse every DIV cycles.
// Assumes a single clock and synchronous active-low reset.
`default_nettype none

module bwd_tick_div #(
    parameter int DIV = 50_000
) (
    input  wire logic sys_clk_i,
    input  wire logic rstn_i,
    output logic      tick_o
);

    logic [31:0] cnt_reg;

    // Free-running count, pulse on wrap
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            cnt_reg <= 32'h0000_0000;
            tick_o  <= 1'b0;
        end else if (cnt_reg == 32'(DIV - 1)) begin
            cnt_reg <= 32'h0000_0000;
            tick_o  <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
            tick_o  <= 1'b0;
        end
    end

endmodule : bwd_tick_div

`default_nettype wire

// ==== src/bwd_top.sv ====
// Board watchdog: a single I/O port arms, refreshes and disarms a timer
// that resets the CPU or raises an interrupt on expiry.
// Assumes host I/O strobes are synchronous to sys_clk_i, one cycle each.
`default_nettype none

module bwd_top
    import bwd_pkg::*;
#(
    parameter int TIMEOUT_TICKS = int'(BWD_TIMEOUT_MS),
    parameter int TICK_CYC      = BWD_TICK_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    input  wire bwd_io_req_t io_req_i,
    input  wire logic        act_irq_sel_i,
    output logic [7:0]       io_rdata_o,
    output logic             io_rvalid_o,
    output logic             cpu_rst_o,
    output logic             irq_o,
    output logic             armed_o
);

    logic        tick;
    logic        sel_hit;
    logic        wr_one;
    logic        wr_zero;
    logic        rd_hit;
    logic        expire;
    logic [15:0] tmo_cnt_reg;
    logic [7:0]  pulse_cnt_reg;
    bwd_action_t action;
    logic        act_sync1_reg;
    logic        act_sync2_reg;
    logic [31:0] since_reg;

    // Expiry window in cycles after a restart, used by the checks below
    localparam int EXP_MIN_CYC = (TIMEOUT_TICKS - 1) * TICK_CYC;
    localparam int EXP_MAX_CYC = TIMEOUT_TICKS * TICK_CYC - 1;

    // Millisecond time base
    bwd_tick_div #(
        .DIV (TICK_CYC)
    ) u_tick (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .tick_o    (tick)
    );

    // Address decode and access qualification
    assign sel_hit = (io_req_i.addr == BWD_PORT_ADDR);
    assign wr_one  = io_req_i.wr && sel_hit && (io_req_i.wdata == BWD_CODE_REFRESH);
    assign wr_zero = io_req_i.wr && sel_hit && (io_req_i.wdata == BWD_CODE_DISARM);
    assign rd_hit  = io_req_i.rd && sel_hit;
    // Static action choice; low selects reset, the default
    assign action  = act_sync2_reg ? BWD_ACT_IRQ : BWD_ACT_RESET;
    assign expire  = armed_o && tick && (tmo_cnt_reg == 16'(TIMEOUT_TICKS - 1));

    // Two flip-flops on the off-chip action pin; reset clears both
    // so the reset action holds until the pin has settled
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            act_sync1_reg <= 1'b0;
            act_sync2_reg <= 1'b0;
        end else begin
            act_sync1_reg <= act_irq_sel_i;
            act_sync2_reg <= act_sync1_reg;
        end
    end

    // Armed state; disarm write beats a read in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            armed_o <= BWD_RST_ARMED[0];
        end else if (wr_zero) begin
            armed_o <= 1'b0;
        end else if (wr_one || rd_hit) begin
            armed_o <= 1'b1;
        end else if (expire) begin
            armed_o <= 1'b0;
        end
    end

    // Timeout counter in ticks, restarted by refresh or arming read
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            tmo_cnt_reg <= 16'h0000;
        end else if (wr_one || wr_zero || (rd_hit && !armed_o) || !armed_o) begin
            tmo_cnt_reg <= 16'h0000;
        end else if (tick) begin
            tmo_cnt_reg <= expire ? 16'h0000 : tmo_cnt_reg + 16'h0001;
        end
    end

    // Expiry action: fixed reset pulse or sticky interrupt level
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            pulse_cnt_reg <= 8'h00;
            cpu_rst_o     <= 1'b0;
            irq_o         <= 1'b0;
        end else begin
            if (expire && action == BWD_ACT_RESET) begin
                pulse_cnt_reg <= 8'(BWD_RST_PULSE_CYC);
                cpu_rst_o     <= 1'b1;
            end else if (pulse_cnt_reg != 8'h00) begin
                pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
                cpu_rst_o     <= (pulse_cnt_reg != 8'h01);
            end else begin
                cpu_rst_o     <= 1'b0;
            end
            // Interrupt held until the host writes the port again
            if (expire && action == BWD_ACT_IRQ) begin
                irq_o <= 1'b1;
            end else if (io_req_i.wr && sel_hit) begin
                irq_o <= 1'b0;
            end
        end
    end

    // Read data: armed state in bit 0, answer one cycle later
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            io_rdata_o  <= 8'h00;
            io_rvalid_o <= 1'b0;
        end else begin
            io_rvalid_o <= rd_hit;
            if (rd_hit) begin
                io_rdata_o <= 8'(armed_o) << BWD_STAT_ARMED_BIT;
            end
        end
    end

    // Check helper: cycles since the interval last restarted, saturating
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || !armed_o || wr_one) begin
            since_reg <= 32'h0000_0000;
        end else if (since_reg != 32'hFFFF_FFFF) begin
            since_reg <= since_reg + 32'h0000_0001;
        end
    end

    // Checks
    sequence s_refresh;
        wr_one;
    endsequence

    a_refresh_arms: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        s_refresh |=> armed_o && tmo_cnt_reg == 16'h0000)
        else $error("refresh did not arm and restart");

    a_read_arms: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rd_hit && !io_req_i.wr |=> armed_o)
        else $error("port read did not arm");

    a_disarm_quiet: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_zero |=> !armed_o ##1 !expire)
        else $error("disarm write left watchdog armed");

    a_expire_reset: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        expire && !act_irq_sel_i |=> cpu_rst_o [*2])
        else $error("expiry did not pulse cpu reset");

    a_expire_irq: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        expire && act_irq_sel_i |=> irq_o && !cpu_rst_o)
        else $error("expiry did not raise interrupt");

    a_no_early_fire: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        expire |-> since_reg >= 32'(EXP_MIN_CYC) && since_reg <= 32'(EXP_MAX_CYC))
        else $error("expiry outside the timeout window");

    a_read_answer: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rd_hit |=> io_rvalid_o && io_rdata_o[0] == $past(armed_o))
        else $error("read answer wrong");

    a_pulse_ends: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(cpu_rst_o) |-> ##16 !cpu_rst_o)
        else $error("cpu reset pulse length wrong");

    // Reset pulse in steps: expiry, sixteen high cycles, then low
    sequence s_expire_rst;
        expire && !act_irq_sel_i;
    endsequence

    sequence s_rst_body;
        cpu_rst_o [*8] ##1 cpu_rst_o [*8] ##1 !cpu_rst_o;
    endsequence

    a_rst_full_pulse: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        s_expire_rst |=> s_rst_body)
        else $error("cpu reset pulse not held for its full length");

    a_rst_needs_expiry: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(cpu_rst_o) |-> $past(expire))
        else $error("cpu reset rose without an expiry");

    a_irq_needs_expiry: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(irq_o) |-> $past(expire))
        else $error("interrupt rose without an expiry");

    a_irq_sticky: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        irq_o && !(io_req_i.wr && sel_hit) |=> irq_o)
        else $error("interrupt dropped without a port write");

    a_rvalid_single: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !rd_hit |=> !io_rvalid_o)
        else $error("read answer held too long");

    a_other_addr: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !armed_o && !sel_hit |=> !armed_o)
        else $error("access to another port armed the watchdog");

endmodule : bwd_top

`default_nettype wire

// ==== tb/bwd_bench.sv ====
// Self-checking bench for the board watchdog port and expiry actions.
// Assumes bwd_pkg and bwd_top are compiled first; time base is shortened.
`default_nettype none

module board_watchdog_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import bwd_pkg::*;

    localparam int TICK = 4;
    localparam int TOUT = 5;
    localparam int LO   = (TICK * TOUT * 7) / 10;
    localparam int HI   = (TICK * TOUT * 13) / 10 + 1;
    localparam int LIM  = 60;

    logic        sys_clk_i     = 1'b0;
    logic        rstn_i        = 1'b0;
    bwd_io_req_t io_req_i      = '0;
    logic        act_irq_sel_i = 1'b0;
    logic [7:0]  io_rdata_o;
    logic        io_rvalid_o;
    logic        cpu_rst_o;
    logic        irq_o;
    logic        armed_o;
    int          miscompares   = 0;
    int          checks_done   = 0;
    int          n;

    // Device under test with a 4-cycle tick and 5-tick timeout
    bwd_top #(.TIMEOUT_TICKS(TOUT), .TICK_CYC(TICK)) uut (
        .sys_clk_i    (sys_clk_i),
        .rstn_i       (rstn_i),
        .io_req_i     (io_req_i),
        .act_irq_sel_i(act_irq_sel_i),
        .io_rdata_o   (io_rdata_o),
        .io_rvalid_o  (io_rvalid_o),
        .cpu_rst_o    (cpu_rst_o),
        .irq_o        (irq_o),
        .armed_o      (armed_o)
    );

    // 50 MHz clock
    always #10 sys_clk_i = ~sys_clk_i;

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle port access, driven on falling edges
    task automatic io(input logic wr, input logic rd, input logic [15:0] a,
                      input logic [7:0] d);
        @(negedge sys_clk_i);
        io_req_i = '{wr: wr, rd: rd, addr: a, wdata: d};
        @(negedge sys_clk_i);
        io_req_i = '0;
    endtask : io

    // Bounded wait for reset or interrupt; cyc is LIM if none came
    task automatic wait_evt(input bit must, output int cyc);
        cyc = 0;
        while (cpu_rst_o !== 1'b1 && irq_o !== 1'b1 && cyc < LIM) begin
            @(negedge sys_clk_i);
            cyc++;
        end
        if (must && cyc >= LIM) begin
            miscompares++;
            end_of_test();
        end
    endtask : wait_evt

    task automatic rst_len(output int len);
        len = 0;
        while (cpu_rst_o === 1'b1 && len < LIM) begin
            @(negedge sys_clk_i);
            len++;
        end
        if (len >= LIM) begin
            miscompares++;
            end_of_test();
        end
    endtask : rst_len

    task automatic t_expire;
        io(1'b1, 1'b0, BWD_PORT_ADDR, BWD_CODE_REFRESH);
        check(8'(armed_o), 8'h01);
        wait_evt(1'b1, n);
        check(8'(n >= LO && n <= HI), 8'h01);
        check({cpu_rst_o, irq_o}, 8'h02);
        rst_len(n);
        check(16'(n), 16'(BWD_RST_PULSE_CYC));
        check(8'(armed_o), 8'h00);
        $display("expiry test done");
    endtask : t_expire

    task automatic t_refresh;
        io(1'b1, 1'b0, BWD_PORT_ADDR, BWD_CODE_REFRESH);
        repeat (LO - 2) @(negedge sys_clk_i);
        io(1'b1, 1'b0, BWD_PORT_ADDR, BWD_CODE_REFRESH);
        wait_evt(1'b1, n);
        check(8'(n >= LO && n <= HI), 8'h01);
        rst_len(n);
        $display("refresh test done");
    endtask : t_refresh

    task automatic t_read_disarm;
        io(1'b0, 1'b1, BWD_PORT_ADDR, 8'h00);
        check({io_rvalid_o, io_rdata_o}, 16'h0100);
        check(8'(armed_o), 8'h01);
        io(1'b0, 1'b1, BWD_PORT_ADDR, 8'h00);
        check({io_rvalid_o, io_rdata_o}, 16'h0101);
        io(1'b1, 1'b0, BWD_PORT_ADDR, BWD_CODE_DISARM);
        check(8'(armed_o), 8'h00);
        wait_evt(1'b0, n);
        check(8'(n), 8'(LIM));
        $display("read and disarm test done");
    endtask : t_read_disarm

    task automatic t_irq;
        act_irq_sel_i = 1'b1;
        io(1'b1, 1'b0, BWD_PORT_ADDR, BWD_CODE_REFRESH);
        wait_evt(1'b1, n);
        @(negedge sys_clk_i);
        check({cpu_rst_o, irq_o}, 8'h01);
        io(1'b1, 1'b0, BWD_PORT_ADDR, 8'h5A);
        check(8'(irq_o), 8'h00);
        act_irq_sel_i = 1'b0;
        $display("interrupt test done");
    endtask : t_irq

    task automatic t_other_addr;
        io(1'b1, 1'b0, 16'h0442, BWD_CODE_REFRESH);
        check(8'(armed_o), 8'h00);
        io(1'b0, 1'b1, 16'h0444, 8'h00);
        check({io_rvalid_o, armed_o}, 8'h00);
        $display("other address test done");
    endtask : t_other_addr

    // Main sequence
    initial begin
        repeat (6) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        check({io_rvalid_o, cpu_rst_o, irq_o, armed_o}, 8'h00);
        t_other_addr();
        t_expire();
        t_refresh();
        t_read_disarm();
        t_irq();
        end_of_test();
    end

endmodule : board_watchdog_timer_bench

`default_nettype wire
